// ==== verilog/ofds_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef OFDS_REGS_SVH
`define OFDS_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFDS_ADR_CTRL   8'h00
`define OFDS_ADR_CMD    8'h04
`define OFDS_ADR_TIME   8'h08
`define OFDS_ADR_STAT   8'h0C
`define OFDS_ADR_ISTAT  8'h10
`define OFDS_ADR_IMASK  8'h14
`define OFDS_ADR_ERR    8'h18
`define OFDS_ADR_CONT   8'h1C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OFDS_CTRL_DEN    0
`define OFDS_CTRL_PSEQ   1
`define OFDS_CTRL_FLASH  2
`define OFDS_CMD_PERM    4
`define OFDS_CMD_POS     5
`define OFDS_CMD_GRP     8
`define OFDS_CMD_OUT     12
`define OFDS_IRQ_STOP    0
`define OFDS_IRQ_PHASE   1
`define OFDS_IRQ_FTO     2
`define OFDS_IRQ_DTO     3
`define OFDS_IRQ_REFUSE  4

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define OFDS_TIME_RST    16'h0064
`define OFDS_REBOOT_MAX  3
`define OFDS_TICK_US     1000
`define OFDS_CLK_MHZ     250

`endif

// ==== verilog/ofds_pkg.sv ====
// types shared by the force and disarm supervisor
package ofds_pkg;

   typedef enum logic [3:0]
   {
      OFDS_OP_NONE      = 4'h0,
      OFDS_OP_FORCE_ONE = 4'h1,
      OFDS_OP_FORCE_GRP = 4'h2,
      OFDS_OP_DISARM    = 4'h3,
      OFDS_OP_CLR_ONE   = 4'h4,
      OFDS_OP_CLR_GRP   = 4'h5,
      OFDS_OP_CLR_DIS   = 4'h6,
      OFDS_OP_REBOOT    = 4'h7
   } ofds_op_t;

   typedef enum logic [0:0]
   {
      OFDS_RUN  = 1'h0,
      OFDS_STOP = 1'h1
   } ofds_sup_t;

endpackage

// ==== verilog/ofds_top.sv ====
// output force and disarm supervisor with reboot supervision
//
// Functional notes
// - after three successive failed reboots the device stops itself.
// - stopped device drives red indicator and shows six-digit error code.
// - timed force holds position while timer runs, then normal.
// - permanent force holds position until it is cleared.
// - group force beats single force within the same group.
// - a disarmed contact ignores every force command.
// - force takes effect only when not disarmed and command applied.
// - a disarmed group suppresses switching of its contacts except exempt, latched or held ones.
// - zone interlock and supervision contacts can never be disarmed.
// - timed disarm lasts while its timer runs, then normal.
// - permanent disarm lasts until cancelled.
// - disarm needs unlatched, hold expired, control enabled, command.
// - healthy green only after boot done and protection running.
// - flag raised while calculated phase sequence differs from setting.
// - operator reboot command makes the device reboot.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "ofds_regs.svh"

module ofds_top #(
   parameter int NGRP     = 2,
   parameter int NOUT     = 4,
   parameter int TMR_W    = 16,
   parameter int TICK_CYC = `OFDS_TICK_US * `OFDS_CLK_MHZ,
   parameter int ZI_IDX   = NGRP * NOUT - 2,
   parameter int SC_IDX   = NGRP * NOUT - 1
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             addr,
   input  wire logic [31:0]            wdata,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [31:0]            rdata,
   input  wire logic [NGRP*NOUT-1:0]   prot_out,
   input  wire logic [NGRP*NOUT-1:0]   latched,
   input  wire logic [NGRP*NOUT-1:0]   hold_run,
   input  wire logic                   boot_done,
   input  wire logic                   prot_running,
   input  wire logic                   boot_end,
   input  wire logic                   undefined_state,
   input  wire logic [23:0]            err_code_in,
   input  wire logic                   calc_seq,
   output logic      [NGRP*NOUT-1:0]   contact_out,
   output logic                        led_red,
   output logic                        led_flash,
   output logic                        led_green,
   output logic                        stopped,
   output logic      [23:0]            err_code,
   output logic                        reboot_req,
   output logic                        phase_mis,
   output logic                        irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   localparam int NC = NGRP * NOUT;
   localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam logic [NC-1:0] EXEMPT = (NC'(1) << ZI_IDX) | (NC'(1) << SC_IDX);

   typedef struct packed {
      logic [NC-1:0]               out;
      logic [NC-1:0]               sf_act;
      logic [NC-1:0]               sf_perm;
      logic [NC-1:0]               sf_pos;
      logic [NC-1:0][TMR_W-1:0]    sf_tmr;
      logic [NGRP-1:0]             gf_act;
      logic [NGRP-1:0]             gf_perm;
      logic [NGRP-1:0]             gf_pos;
      logic [NGRP-1:0][TMR_W-1:0]  gf_tmr;
      logic [NGRP-1:0]             dis_act;
      logic [NGRP-1:0]             dis_perm;
      logic [NGRP-1:0][TMR_W-1:0]  dis_tmr;
      logic [TW-1:0]               tick_cnt;
      logic                        tick;
      logic [2:0]                  ctrl;
      logic [TMR_W-1:0]            tmo;
      ofds_pkg::ofds_sup_t         sup;
      logic [1:0]                  fails;
      logic [23:0]                 err;
      logic                        led_red;
      logic                        led_flash;
      logic                        led_green;
      logic                        reboot_req;
      logic                        phase_mis;
      logic [4:0]                  istat;
      logic [4:0]                  imask;
      logic                        irq;
      logic [31:0]                 rdata;
   } ofds_st_t;

   function automatic ofds_st_t ofds_rst_val();
      ofds_st_t v;
      v = '0;
      v.tmo = TMR_W'(`OFDS_TIME_RST);
      return v;
   endfunction

   ofds_st_t         s_r;
   ofds_st_t         s_nxt;
   logic [NC-1:0]    dis_v;
   logic [NC-1:0]    frc_v;
   logic [TMR_W-1:0] ld_v;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      int g;
      int o;
      int idx;
      logic ok;
      logic [4:0] ev;
      logic [4:0] w1c;
      ofds_pkg::ofds_op_t op;
      g   = 0;
      o   = 0;
      idx = 0;
      ok  = 1'b0;
      ev  = 5'h00;
      w1c = 5'h00;
      op  = ofds_pkg::ofds_op_t'(wdata[3:0]);
      s_nxt = s_r;
      s_nxt.reboot_req = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      // zero timeout would never run; treat as one tick
      ld_v = (s_r.tmo == '0) ? TMR_W'(1) : s_r.tmo;

      if (s_r.tick_cnt == TW'(TICK_CYC - 1))
      begin
         s_nxt.tick_cnt = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.tick_cnt = s_r.tick_cnt + TW'(1);
         s_nxt.tick = 1'b0;
      end

      for (int i = 0; i < NGRP; i++)
      begin
         if (s_r.tick && s_r.gf_act[i] && !s_r.gf_perm[i])
         begin
            s_nxt.gf_tmr[i] = s_r.gf_tmr[i] - TMR_W'(1);
            if (s_r.gf_tmr[i] <= TMR_W'(1))
            begin
               s_nxt.gf_act[i] = 1'b0;
               ev[`OFDS_IRQ_FTO] = 1'b1;
            end
         end
         if (s_r.tick && s_r.dis_act[i] && !s_r.dis_perm[i])
         begin
            s_nxt.dis_tmr[i] = s_r.dis_tmr[i] - TMR_W'(1);
            if (s_r.dis_tmr[i] <= TMR_W'(1))
            begin
               s_nxt.dis_act[i] = 1'b0;
               ev[`OFDS_IRQ_DTO] = 1'b1;
            end
         end
      end
      for (int c = 0; c < NC; c++)
      begin
         if (s_r.tick && s_r.sf_act[c] && !s_r.sf_perm[c])
         begin
            s_nxt.sf_tmr[c] = s_r.sf_tmr[c] - TMR_W'(1);
            if (s_r.sf_tmr[c] <= TMR_W'(1))
            begin
               s_nxt.sf_act[c] = 1'b0;
               ev[`OFDS_IRQ_FTO] = 1'b1;
            end
         end
      end

      // commands come after timers so a restart wins over expiry
      if (wr_en)
      begin
         g   = int'(wdata[`OFDS_CMD_GRP +: 4]);
         o   = int'(wdata[`OFDS_CMD_OUT +: 4]);
         idx = g * NOUT + o;
         ok  = (g < NGRP) && (o < NOUT);
         case (addr)
            `OFDS_ADR_CTRL:  s_nxt.ctrl = wdata[2:0];
            `OFDS_ADR_TIME:  s_nxt.tmo = wdata[TMR_W-1:0];
            `OFDS_ADR_IMASK: s_nxt.imask = wdata[4:0];
            `OFDS_ADR_ISTAT: w1c = wdata[4:0];
            `OFDS_ADR_CMD:
            begin
               if (op == ofds_pkg::OFDS_OP_FORCE_ONE && ok)
               begin
                  s_nxt.sf_act[idx]  = 1'b1;
                  s_nxt.sf_perm[idx] = wdata[`OFDS_CMD_PERM];
                  s_nxt.sf_pos[idx]  = wdata[`OFDS_CMD_POS];
                  s_nxt.sf_tmr[idx]  = ld_v;
               end
               if (op == ofds_pkg::OFDS_OP_FORCE_GRP && g < NGRP)
               begin
                  s_nxt.gf_act[g]  = 1'b1;
                  s_nxt.gf_perm[g] = wdata[`OFDS_CMD_PERM];
                  s_nxt.gf_pos[g]  = wdata[`OFDS_CMD_POS];
                  s_nxt.gf_tmr[g]  = ld_v;
               end
               if (op == ofds_pkg::OFDS_OP_DISARM && g < NGRP)
               begin
                  if (s_r.ctrl[`OFDS_CTRL_DEN])
                  begin
                     s_nxt.dis_act[g]  = 1'b1;
                     s_nxt.dis_perm[g] = wdata[`OFDS_CMD_PERM];
                     s_nxt.dis_tmr[g]  = ld_v;
                  end
                  else
                     ev[`OFDS_IRQ_REFUSE] = 1'b1;
               end
               if (op == ofds_pkg::OFDS_OP_CLR_ONE && ok)
                  s_nxt.sf_act[idx] = 1'b0;
               if (op == ofds_pkg::OFDS_OP_CLR_GRP && g < NGRP)
                  s_nxt.gf_act[g] = 1'b0;
               if (op == ofds_pkg::OFDS_OP_CLR_DIS && g < NGRP)
                  s_nxt.dis_act[g] = 1'b0;
               if (op == ofds_pkg::OFDS_OP_REBOOT)
                  s_nxt.reboot_req = 1'b1;
            end
            default: ;
         endcase
      end

      // contacts
      for (int c = 0; c < NC; c++)
      begin
         dis_v[c] = s_r.dis_act[c / NOUT] & s_r.ctrl[`OFDS_CTRL_DEN]
                    & ~latched[c] & ~hold_run[c] & ~EXEMPT[c];
         frc_v[c] = s_r.gf_act[c / NOUT] | s_r.sf_act[c];
         if (dis_v[c])
            s_nxt.out[c] = s_r.out[c];
         else if (s_r.gf_act[c / NOUT])
            s_nxt.out[c] = s_r.gf_pos[c / NOUT];
         else if (s_r.sf_act[c])
            s_nxt.out[c] = s_r.sf_pos[c];
         else
            s_nxt.out[c] = prot_out[c];
      end

      unique case (s_r.sup)
         ofds_pkg::OFDS_RUN:
         begin
            if (boot_end && undefined_state)
            begin
               if (s_r.fails == 2'(`OFDS_REBOOT_MAX - 1))
               begin
                  s_nxt.sup = ofds_pkg::OFDS_STOP;
                  s_nxt.err = err_code_in;
                  ev[`OFDS_IRQ_STOP] = 1'b1;
               end
               else
               begin
                  s_nxt.fails = s_r.fails + 2'h1;
                  s_nxt.reboot_req = 1'b1;
               end
            end
            else if (boot_end)
               s_nxt.fails = 2'h0;
         end
         // stopped is left only through reset
         ofds_pkg::OFDS_STOP: ;
      endcase

      s_nxt.led_red = (s_r.sup == ofds_pkg::OFDS_STOP);
      s_nxt.led_flash = (s_r.sup == ofds_pkg::OFDS_STOP)
                        & s_r.ctrl[`OFDS_CTRL_FLASH];
      s_nxt.led_green = boot_done & prot_running
                        & (s_r.sup == ofds_pkg::OFDS_RUN);
      s_nxt.phase_mis = calc_seq != s_r.ctrl[`OFDS_CTRL_PSEQ];
      ev[`OFDS_IRQ_PHASE] = s_nxt.phase_mis & ~s_r.phase_mis;

      // set wins over clear
      s_nxt.istat = (s_r.istat & ~w1c) | ev;
      s_nxt.irq = |(s_nxt.istat & s_nxt.imask);

      if (rd_en)
      begin
         case (addr)
            `OFDS_ADR_CTRL:  s_nxt.rdata = 32'(s_r.ctrl);
            `OFDS_ADR_TIME:  s_nxt.rdata = 32'(s_r.tmo);
            `OFDS_ADR_STAT:  s_nxt.rdata = 32'({s_r.fails, s_r.phase_mis,
                                  s_r.led_green, s_r.sup == ofds_pkg::OFDS_STOP});
            `OFDS_ADR_ISTAT: s_nxt.rdata = 32'(s_r.istat);
            `OFDS_ADR_IMASK: s_nxt.rdata = 32'(s_r.imask);
            `OFDS_ADR_ERR:   s_nxt.rdata = 32'(s_r.err);
            `OFDS_ADR_CONT:  s_nxt.rdata = 32'(s_r.out);
            default:         s_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= ofds_rst_val();
      else
         s_r <= s_nxt;
   end

   assign rdata       = s_r.rdata;
   assign contact_out = s_r.out;
   assign led_red     = s_r.led_red;
   assign led_flash   = s_r.led_flash;
   assign led_green   = s_r.led_green;
   assign stopped     = s_r.sup == ofds_pkg::OFDS_STOP;
   assign err_code    = s_r.err;
   assign reboot_req  = s_r.reboot_req;
   assign phase_mis   = s_r.phase_mis;
   assign irq         = s_r.irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_third_fail;
      boot_end && undefined_state && s_r.fails == 2'h2
         && s_r.sup == ofds_pkg::OFDS_RUN;
   endsequence

   sequence s_cmd(logic [3:0] code);
      wr_en && addr == `OFDS_ADR_CMD && wdata[3:0] == code
         && wdata[`OFDS_CMD_GRP +: 4] == 4'h0;
   endsequence

   a_stop_third_fail: assert property (s_third_fail |=> stopped)
      else $error("no stop after third failed reboot");
   a_stop_red_led: assert property (stopped |-> ##1
      led_red && !led_green && $stable(err_code))
      else $error("stopped without red indicator");
   a_timed_force_end: assert property (s_r.tick && s_r.sf_act[1]
      && !s_r.sf_perm[1] && s_r.sf_tmr[1] == TMR_W'(1) && !wr_en
      |=> !s_r.sf_act[1])
      else $error("timed single force did not expire");
   a_perm_force_keep: assert property (s_r.gf_act[0]
      && s_r.gf_perm[0] && !wr_en |=> s_r.gf_act[0])
      else $error("permanent force dropped");
   a_group_wins: assert property (!dis_v[0] && s_r.gf_act[0]
      && s_r.sf_act[0] |=> contact_out[0] == $past(s_r.gf_pos[0]))
      else $error("single force beat group force");
   a_disarm_freeze: assert property (dis_v[4]
      |=> $stable(contact_out[4]))
      else $error("disarmed contact switched");
   a_force_applied: assert property (
      s_cmd(ofds_pkg::OFDS_OP_FORCE_GRP) ##1 (!dis_v[0] && !wr_en)
      |=> contact_out[0] == s_r.gf_pos[0])
      else $error("force command not followed");
   a_exempt_normal: assert property (!frc_v[ZI_IDX]
      |=> contact_out[ZI_IDX] == $past(prot_out[ZI_IDX]))
      else $error("exempt contact did not follow protection");
   a_timed_disarm: assert property (s_r.tick && s_r.dis_act[1]
      && !s_r.dis_perm[1] && s_r.dis_tmr[1] == TMR_W'(1) && !wr_en
      |=> !s_r.dis_act[1])
      else $error("timed disarm did not expire");
   a_perm_disarm: assert property (s_r.dis_act[1]
      && s_r.dis_perm[1] && !wr_en |=> s_r.dis_act[1])
      else $error("permanent disarm dropped");
   // latched, held or disabled contact keeps following protection
   a_disarm_gate: assert property ((latched[4] || hold_run[4]
      || !s_r.ctrl[`OFDS_CTRL_DEN]) && !frc_v[4]
      |=> contact_out[4] == $past(prot_out[4]))
      else $error("contact disarmed without all conditions");
   a_green_boot: assert property (led_green |->
      $past(boot_done) && $past(prot_running) && !stopped)
      else $error("green indicator before boot complete");
   a_phase_flag: assert property (
      calc_seq != s_r.ctrl[`OFDS_CTRL_PSEQ]
      && !wr_en |=> phase_mis ##1 (calc_seq == s_r.ctrl[`OFDS_CTRL_PSEQ])
      || phase_mis)
      else $error("phase mismatch flag missing");
   a_reboot_cmd: assert property (
      s_cmd(ofds_pkg::OFDS_OP_REBOOT) |=> reboot_req
      ##1 (!reboot_req || $past(wr_en) || $past(boot_end)))
      else $error("reboot command not issued");
   a_timer_restart: assert property (
      s_cmd(ofds_pkg::OFDS_OP_FORCE_GRP)
      |=> s_r.gf_act[0] && s_r.gf_tmr[0] == $past(ld_v))
      else $error("force timer not restarted");

endmodule // ofds_top

// ==== test/ofds_boot_model.sv ====
// partner model: boot sequencer that answers reboot requests
`timescale 1ns/1ps
module ofds_boot_model #(
   parameter int DLY = 10
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic reboot_req,
   input  wire logic stuck,
   output logic      boot_end,
   output logic      undefined_state,
   output logic      boot_done,
   output logic      prot_running
);
   int cnt;
   // ---------------------------------------------------------------
   // boot sequence
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt             <= 0;
         boot_end        <= 1'h0;
         undefined_state <= 1'h0;
         boot_done       <= 1'h1;
         prot_running    <= 1'h1;
      end
      else
      begin
         boot_end <= 1'h0;
         // only valid with boot_end, so it wanders
         undefined_state <= ~undefined_state;
         if (reboot_req)
         begin
            cnt          <= DLY;
            boot_done    <= 1'h0;
            prot_running <= 1'h0;
         end
         else if (cnt == 1)
         begin
            cnt <= 0;
            boot_end <= 1'h1;
            undefined_state <= stuck;
            boot_done       <= !stuck;
            prot_running    <= !stuck;
         end
         else if (cnt > 1)
            cnt <= cnt - 1;
      end
   end
endmodule // ofds_boot_model

// ==== test/test_output_force_disarm_supervisor.sv ====
// self-checking bench of the force and disarm supervisor
`timescale 1ns/1ps
`include "ofds_regs.svh"
module test_output_force_disarm_supervisor;
   typedef struct packed {
      logic pseq; logic [7:0] prot; logic calc; logic [7:0] cont; logic mis;
   } ofds_row_t;
   logic        ref_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr_en = 1'h0;
   logic        rd_en = 1'h0;
   logic [31:0] rdata;
   logic [7:0]  prot_out = 8'h00;
   logic [7:0]  latched = 8'h00;
   logic [7:0]  hold_run = 8'h00;
   logic        boot_done, prot_running, boot_end, undefined_state;
   logic        calc_seq = 1'h0;
   logic        stuck = 1'h0;
   logic [7:0]  contact_out;
   logic        led_red, led_flash, led_green, stopped;
   logic        reboot_req, phase_mis, irq;
   logic [23:0] err_code;
   logic [31:0] d;
   int          failures = 0;
   int          total_checks = 0;
   int          req_cnt = 0;
   int          base;
   ofds_row_t   rows [4] = '{'{1'h0, 8'h00, 1'h0, 8'h00, 1'h0},
      '{1'h0, 8'hA5, 1'h1, 8'hA5, 1'h1}, '{1'h1, 8'h5A, 1'h1, 8'h5A, 1'h0},
      '{1'h1, 8'hFF, 1'h0, 8'hFF, 1'h1}};

   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (reboot_req === 1'h1) req_cnt <= req_cnt + 1;

   ofds_top #(.TICK_CYC(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .prot_out(prot_out), .latched(latched),
      .hold_run(hold_run), .boot_done(boot_done),
      .prot_running(prot_running), .boot_end(boot_end),
      .undefined_state(undefined_state), .err_code_in(24'h0A1B2C),
      .calc_seq(calc_seq), .contact_out(contact_out), .led_red(led_red),
      .led_flash(led_flash), .led_green(led_green), .stopped(stopped),
      .err_code(err_code), .reboot_req(reboot_req),
      .phase_mis(phase_mis), .irq(irq));
   ofds_boot_model u_boot (.ref_clk(ref_clk), .rst_n(rst_n),
      .reboot_req(reboot_req), .stuck(stuck), .boot_end(boot_end),
      .undefined_state(undefined_state), .boot_done(boot_done),
      .prot_running(prot_running));

   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'h1;
      @(posedge ref_clk);
      wr_en <= 1'h0;
   endtask
   task automatic chk_word(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, g);
      chk_word(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'h1;
      @(posedge ref_clk);
      rd_en <= 1'h0;
      #1;
      d = rdata;
      chk_word("read data", e, d);
   endtask
   function automatic logic [31:0] cmd(input logic [3:0] op,
      input logic perm, pos, input logic [3:0] grp, outp);
      return {16'h0000, outp, grp, 2'h0, pos, perm, op};
   endfunction
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // watchdog, about twenty times the expected run
   // ---------------------------------------------------------------
   initial
   begin
      #20000;
      failures++;
      $display("Error watchdog expected done seen timeout");
      results();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      rdchk(`OFDS_ADR_TIME, 32'h00000064);
      rdchk(`OFDS_ADR_CMD, 32'h0);
      rdchk(8'h20, 32'h0);
      $display("test reset values done");
      foreach (rows[i])
      begin
         wr(`OFDS_ADR_CTRL, {30'h0, rows[i].pseq, 1'h0});
         prot_out <= rows[i].prot;
         calc_seq <= rows[i].calc;
         cyc(3);
         chk_word("contacts", {24'h0, rows[i].cont}, {24'h0, contact_out});
         chk_bit("phase mismatch", rows[i].mis, phase_mis);
      end
      $display("test row table done");
      prot_out <= 8'h00;
      calc_seq <= 1'h0;
      wr(`OFDS_ADR_CTRL, 32'h0);
      wr(`OFDS_ADR_TIME, 32'h2);
      wr(`OFDS_ADR_ISTAT, 32'h1F);
      wr(`OFDS_ADR_CMD, cmd(4'h1, 1'h0, 1'h1, 4'h0, 4'h1));
      cyc(3);
      chk_bit("timed force on", 1'h1, contact_out[1]);
      cyc(14);
      chk_bit("timed force off", 1'h0, contact_out[1]);
      rdchk(`OFDS_ADR_ISTAT, 32'h4);
      prot_out <= 8'h01;
      wr(`OFDS_ADR_CMD, cmd(4'h1, 1'h1, 1'h0, 4'h0, 4'h0));
      wr(`OFDS_ADR_CMD, cmd(4'h2, 1'h1, 1'h1, 4'h0, 4'h0));
      cyc(16);
      chk_word("group force", 32'hF, {28'h0, contact_out[3:0]});
      wr(`OFDS_ADR_CMD, cmd(4'h5, 1'h0, 1'h0, 4'h0, 4'h0));
      cyc(3);
      chk_word("single force", 32'h0, {28'h0, contact_out[3:0]});
      wr(`OFDS_ADR_CMD, cmd(4'h4, 1'h0, 1'h0, 4'h0, 4'h0));
      cyc(3);
      chk_bit("force removed", 1'h1, contact_out[0]);
      wr(`OFDS_ADR_CMD, cmd(4'h1, 1'h0, 1'h1, 4'h0, 4'h2));
      cyc(2);
      wr(`OFDS_ADR_CMD, cmd(4'h1, 1'h0, 1'h1, 4'h0, 4'h2));
      cyc(5);
      chk_bit("force restart", 1'h1, contact_out[2]);
      cyc(14);
      $display("test forcing done");
      wr(`OFDS_ADR_ISTAT, 32'h1F);
      wr(`OFDS_ADR_CMD, cmd(4'h3, 1'h1, 1'h0, 4'h1, 4'h0));
      rdchk(`OFDS_ADR_ISTAT, 32'h10);
      wr(`OFDS_ADR_IMASK, 32'h10);
      cyc(2);
      chk_bit("irq raised", 1'h1, irq);
      wr(`OFDS_ADR_ISTAT, 32'h10);
      cyc(2);
      chk_bit("irq cleared", 1'h0, irq);
      wr(`OFDS_ADR_IMASK, 32'h0);
      prot_out <= 8'h00;
      latched  <= 8'h10;
      wr(`OFDS_ADR_CTRL, 32'h1);
      wr(`OFDS_ADR_CMD, cmd(4'h3, 1'h1, 1'h0, 4'h1, 4'h0));
      prot_out <= 8'hF0;
      cyc(20);
      chk_word("perm disarm", 32'hD0, {24'h0, contact_out});
      rdchk(`OFDS_ADR_CONT, 32'hD0);
      wr(`OFDS_ADR_CMD, cmd(4'h1, 1'h1, 1'h1, 4'h1, 4'h1));
      cyc(3);
      chk_bit("disarmed ignores force", 1'h0, contact_out[5]);
      prot_out <= 8'hD0;
      wr(`OFDS_ADR_CTRL, 32'h0);
      cyc(3);
      chk_bit("armed follows force", 1'h1, contact_out[5]);
      wr(`OFDS_ADR_CMD, cmd(4'h4, 1'h0, 1'h0, 4'h1, 4'h1));
      wr(`OFDS_ADR_CMD, cmd(4'h6, 1'h0, 1'h0, 4'h1, 4'h0));
      latched  <= 8'h00;
      prot_out <= 8'h00;
      hold_run <= 8'h20;
      wr(`OFDS_ADR_CTRL, 32'h1);
      wr(`OFDS_ADR_ISTAT, 32'h1F);
      wr(`OFDS_ADR_CMD, cmd(4'h3, 1'h0, 1'h0, 4'h1, 4'h0));
      cyc(3);
      prot_out <= 8'hF0;
      cyc(1);
      chk_word("timed disarm", 32'hE0, {24'h0, contact_out});
      cyc(14);
      chk_word("disarm expired", 32'hF0, {24'h0, contact_out});
      rdchk(`OFDS_ADR_ISTAT, 32'h8);
      hold_run <= 8'h00;
      $display("test disarming done");
      wr(`OFDS_ADR_CMD, cmd(4'h7, 1'h0, 1'h0, 4'h0, 4'h0));
      cyc(3);
      chk_bit("green while booting", 1'h0, led_green);
      for (int i = 0; i < 40 && led_green !== 1'h1; i++) cyc(1);
      chk_bit("green after boot", 1'h1, led_green);
      rdchk(`OFDS_ADR_STAT, 32'h2);
      stuck <= 1'h1;
      base = req_cnt;
      wr(`OFDS_ADR_CTRL, 32'h4);
      wr(`OFDS_ADR_IMASK, 32'h1);
      wr(`OFDS_ADR_CMD, cmd(4'h7, 1'h0, 1'h0, 4'h0, 4'h0));
      for (int i = 0; i < 100 && stopped !== 1'h1; i++) cyc(1);
      chk_bit("stopped", 1'h1, stopped);
      chk_word("reboots", 32'h3, req_cnt - base);
      cyc(2);
      chk_bit("red", 1'h1, led_red);
      chk_bit("flash", 1'h1, led_flash);
      chk_word("error code", 32'h000A1B2C, {8'h0, err_code});
      rdchk(`OFDS_ADR_ERR, 32'h000A1B2C);
      chk_bit("green stopped", 1'h0, led_green);
      chk_bit("stop irq", 1'h1, irq);
      wr(`OFDS_ADR_ISTAT, 32'h1);
      cyc(2);
      chk_bit("stop irq cleared", 1'h0, irq);
      $display("test supervision done");
      stuck <= 1'h0;
      rst_n <= 1'h0;
      cyc(2);
      chk_bit("stopped in reset", 1'h0, stopped);
      chk_word("contacts in reset", 32'h0, {24'h0, contact_out});
      rst_n <= 1'h1;
      rdchk(`OFDS_ADR_TIME, 32'h00000064);
      $display("test second reset done");
      results();
   end
endmodule // test_output_force_disarm_supervisor
